// ==== rtl/pfl_defs.svh ====
// timing counts, strap address values and led blink rates for the supply supervisor
`ifndef PFL_DEFS_SVH
`define PFL_DEFS_SVH
`define PFL_CLK_HZ          25000000
`define PFL_BLINK1_HZ       1
`define PFL_BLINK2_HZ       2
`define PFL_BLINK1_HALF     (`PFL_CLK_HZ / (2 * `PFL_BLINK1_HZ))
`define PFL_BLINK2_HALF     (`PFL_CLK_HZ / (2 * `PFL_BLINK2_HZ))
`define PFL_PSON_REL_MS     1000
`define PFL_PSON_REL_CYC    (`PFL_CLK_HZ / 1000 * `PFL_PSON_REL_MS)
`define PFL_AC_REL_MS       15000
`define PFL_AC_REL_CYC      (`PFL_CLK_HZ / 1000 * `PFL_AC_REL_MS)
`define PFL_CLOSED_LOOP_THROTTLE_MS         2
`define PFL_CLOSED_LOOP_THROTTLE_CYC        (`PFL_CLK_HZ / 1000 * `PFL_CLOSED_LOOP_THROTTLE_MS)
`define PFL_ACLOSS_MS       4
`define PFL_ACLOSS_CYC      (`PFL_CLK_HZ / 1000 * `PFL_ACLOSS_MS)
`define PFL_FRU_ADDR0       8'hA0
`define PFL_FRU_ADDR1       8'hA2
`define PFL_PMI_ADDR0       8'hB0
`define PFL_PMI_ADDR1       8'hB2
`define PFL_ADDR_STEP       8'h02
`endif

// ==== rtl/pfl_pkg.sv ====
// types shared by the supply supervisor files
package pfl_pkg;
    typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_AMBER} pfl_color_t;

    typedef struct packed {
        logic overcurrentTrip;
        logic shortCircuitTrip;
        logic overvoltTrip;
        logic overpowerTrip;
        logic fanFail;
        logic generalFail;
    } pfl_crit_t;

    typedef struct packed {
        logic tempWarn;
        logic highPower;
        logic highCurrent;
        logic slowFan;
        logic underVolt;
    } pfl_warn_t;

    typedef struct packed {
        logic [7:0] fruAddr;
        logic [7:0] pmiAddr;
    } pfl_addr_t;
endpackage : pfl_pkg

// ==== rtl/pfl_blinker.sv ====
// free running square wave of programmable half period
`timescale 1ns/100ps
module pfl_blinker import pfl_pkg::*; #(
    parameter int HALF = 12500000
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic clkEn,
    output logic      blink
);
    localparam int W = $clog2(HALF + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= '0;
            blink <= 1'b0;
        end else if (clkEn) begin
            if (cnt_q == W'(HALF - 1)) begin
                cnt_q <= '0;
                blink <= ~blink;
            end else begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end
endmodule : pfl_blinker

// ==== rtl/pfl_supervisor.sv ====
// fault latch, alert, strap address decode and status led of the supply
//
// What this block does
// - over-current turns main output off and latches until released.
// - short circuit also forces main off into the same latch.
// - latch released only by power-on request toggle or input power loss.
// - standby rail never latches; follows its own fault level.
// - alert asserts on high-power warning, ahead of over-power shutdown.
// - temperature warning asserts alert; shutdown only if load stays high 2 ms.
// - alert asserts within 4 ms of input voltage reaching zero.
// - alert is active low, driven for critical and warning events.
// - alert asserted together with steady or blinking amber led.
// - strap low reads 0, high reads 1; open straps read high.
// - information device at A0h for straps 0/0, A2h for 0/1.
// - power management device at B0h for straps 0/0, B2h for 0/1.
// - led green when main on and good; off with no input anywhere and no fault, update or warning.
// - led blinks green 1 Hz on standby only or smart standby.
// - led amber when own input lost but parallel supply powered.
// - led blinks amber 1 Hz during warnings while running and not updating.
// - led amber after a critical shutdown.
// - led blinks green 2 Hz during firmware update with no fault present.
`timescale 1ns/100ps
`include "pfl_defs.svh"
module pfl_supervisor import pfl_pkg::*; #(
    parameter int PSON_REL_CYC = `PFL_PSON_REL_CYC,
    parameter int AC_REL_CYC   = `PFL_AC_REL_CYC,
    parameter int CLOSED_LOOP_THROTTLE_CYC     = `PFL_CLOSED_LOOP_THROTTLE_CYC,
    parameter int BLINK1_HALF  = `PFL_BLINK1_HALF,
    parameter int BLINK2_HALF  = `PFL_BLINK2_HALF
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    input  wire logic       powerOnReq_n,
    input  wire logic       acPresent,
    input  wire logic       peerAcPresent,
    input  wire logic       mainInReg,
    input  wire logic       smartStandby,
    input  wire logic       fwUpdate,
    input  wire logic       loadAboveRating,
    input  wire logic       standbyFault,
    input  wire logic       addr_strap_lo,
    input  wire logic       addr_strap_hi,
    input  wire pfl_crit_t  crit,
    input  wire pfl_warn_t  warn,
    output logic            mainEnable,
    output logic            standby_rail_en,
    output logic            faultLatched,
    output logic            alert_n,
    output logic            ledGreen,
    output logic            ledAmber,
    output pfl_addr_t       addrs
);
    localparam int PW = $clog2(PSON_REL_CYC + 1);
    localparam int AW = $clog2(AC_REL_CYC + 1);
    localparam int CW = $clog2(CLOSED_LOOP_THROTTLE_CYC + 1);

    function automatic logic [7:0] stapAddr(input logic [7:0] base, input logic lo, input logic hi);
        // the low strap adds one address step; the high strap weighs two
        stapAddr = base + (lo ? `PFL_ADDR_STEP : 8'h00) + (hi ? (`PFL_ADDR_STEP << 1) : 8'h00);
    endfunction : stapAddr

    logic          blink1;
    logic          blink2;
    logic [PW-1:0] psonHighCnt_q;
    logic [AW-1:0] acOffCnt_q;
    logic [CW-1:0] clstCnt_q;
    logic          latch_q;
    logic          clstTrip_q;
    logic          releaseNow;
    logic          anyCrit;
    logic          anyWarn;
    logic          faultNow;
    pfl_color_t    color_d;
    logic          amberSteady;
    logic          amberBlink;

    pfl_blinker #(.HALF(BLINK1_HALF)) uBlink1 (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .blink   (blink1)
    );

    pfl_blinker #(.HALF(BLINK2_HALF)) uBlink2 (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .blink   (blink2)
    );

    assign anyCrit  = crit.overcurrentTrip | crit.shortCircuitTrip | crit.overvoltTrip
                    | crit.overpowerTrip | crit.fanFail | crit.generalFail;
    assign anyWarn  = |warn;
    assign faultNow = anyCrit | clstTrip_q;
    // release once request held high or input held off long enough
    assign releaseNow = (psonHighCnt_q == PW'(PSON_REL_CYC)) | (acOffCnt_q == AW'(AC_REL_CYC));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            psonHighCnt_q <= '0;
        end else if (clkEn) begin
            if (!powerOnReq_n) begin
                psonHighCnt_q <= '0;
            end else if (psonHighCnt_q != PW'(PSON_REL_CYC)) begin
                psonHighCnt_q <= psonHighCnt_q + PW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acOffCnt_q <= '0;
        end else if (clkEn) begin
            if (acPresent) begin
                acOffCnt_q <= '0;
            end else if (acOffCnt_q != AW'(AC_REL_CYC)) begin
                acOffCnt_q <= acOffCnt_q + AW'(1);
            end
        end
    end

    // load must drop below rating within the window after a temperature warning
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clstCnt_q  <= '0;
            clstTrip_q <= 1'b0;
        end else if (clkEn) begin
            if (!(warn.tempWarn && loadAboveRating)) begin
                clstCnt_q  <= '0;
                clstTrip_q <= 1'b0;
            end else if (clstCnt_q != CW'(CLOSED_LOOP_THROTTLE_CYC)) begin
                clstCnt_q <= clstCnt_q + CW'(1);
            end else begin
                clstTrip_q <= 1'b1;
            end
        end
    end

    // a new fault wins over a release in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            latch_q <= 1'b0;
        end else if (clkEn) begin
            if (faultNow) begin
                latch_q <= 1'b1;
            end else if (releaseNow) begin
                latch_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mainEnable      <= 1'b0;
            standby_rail_en <= 1'b0;
            faultLatched    <= 1'b0;
        end else if (clkEn) begin
            mainEnable      <= !powerOnReq_n && acPresent && !latch_q && !faultNow;
            standby_rail_en <= acPresent && !standbyFault;
            faultLatched    <= latch_q || faultNow;
        end
    end

    always_comb begin
        amberSteady = 1'b0;
        amberBlink  = 1'b0;
        color_d     = LED_OFF;
        if (latch_q || faultNow) begin
            color_d     = LED_AMBER;
            amberSteady = 1'b1;
        end else if (fwUpdate) begin
            color_d = blink2 ? LED_GREEN : LED_OFF;
        end else if (anyWarn) begin
            color_d    = blink1 ? LED_AMBER : LED_OFF;
            amberBlink = 1'b1;
        end else if (!acPresent && peerAcPresent) begin
            color_d     = LED_AMBER;
            amberSteady = 1'b1;
        end else if (!acPresent) begin
            color_d = LED_OFF;
        end else if (mainEnable && mainInReg && !smartStandby) begin
            color_d = LED_GREEN;
        end else begin
            color_d = blink1 ? LED_GREEN : LED_OFF;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ledGreen <= 1'b0;
            ledAmber <= 1'b0;
            alert_n  <= 1'b1;
        end else if (clkEn) begin
            ledGreen <= (color_d == LED_GREEN);
            ledAmber <= (color_d == LED_AMBER);
            // warnings (temp, high power, under-volt) and input loss all pull alert low
            alert_n  <= !(amberSteady || amberBlink || anyCrit || anyWarn || !acPresent);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addrs <= '{fruAddr: `PFL_FRU_ADDR0, pmiAddr: `PFL_PMI_ADDR0};
        end else if (clkEn) begin
            addrs.fruAddr <= stapAddr(`PFL_FRU_ADDR0, addr_strap_lo, addr_strap_hi);
            addrs.pmiAddr <= stapAddr(`PFL_PMI_ADDR0, addr_strap_lo, addr_strap_hi);
        end
    end

    // assertions
    sequence critSeen;
        anyCrit && clkEn;
    endsequence

    sequence mainDown;
        !mainEnable && faultLatched;
    endsequence

    latch_holds_a: assert property (@(posedge ref_clk) disable iff (srst)
        critSeen |=> mainDown) else $error("critical fault did not force main off");

    short_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
        (crit.shortCircuitTrip && clkEn) |=> latch_q) else $error("short circuit not latched");

    latch_release_a: assert property (@(posedge ref_clk) disable iff (srst)
        ($fell(latch_q)) |-> $past(releaseNow)) else $error("latch dropped without release");

    standby_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && acPresent && !standbyFault) |=> standby_rail_en) else $error("standby rail not restored");

    alert_power_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && warn.highPower) |=> !alert_n) else $error("high power warning without alert");

    alert_temp_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && warn.tempWarn) |=> !alert_n) else $error("temperature warning without alert");

    closed_loop_throttle_no_trip_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clstCnt_q != CW'(CLOSED_LOOP_THROTTLE_CYC)) |-> !clstTrip_q) else $error("throttle trip before window");

    alert_acloss_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && !acPresent) |=> !alert_n) else $error("input loss not alerted");

    alert_amber_a: assert property (@(posedge ref_clk) disable iff (srst)
        ledAmber |-> !alert_n) else $error("amber led without alert");

    strap_addr_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && !addr_strap_lo && !addr_strap_hi) |=> (addrs.fruAddr == 8'hA0 && addrs.pmiAddr == 8'hB0))
        else $error("strap 0/0 decode wrong");

    strap_one_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && addr_strap_lo && !addr_strap_hi) |=> (addrs.fruAddr == 8'hA2 && addrs.pmiAddr == 8'hB2))
        else $error("strap 0/1 decode wrong");

    led_dark_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && !acPresent && !peerAcPresent && !faultNow && !latch_q && !fwUpdate && !anyWarn)
        |=> !ledGreen && !ledAmber) else $error("led lit with no input");

    fw_priority_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && fwUpdate && !faultNow && !latch_q) |=> !ledAmber) else $error("update shows amber");

    crit_amber_a: assert property (@(posedge ref_clk) disable iff (srst)
        (clkEn && latch_q) |=> ledAmber && !ledGreen) else $error("latched fault not steady amber");
endmodule : pfl_supervisor

// ==== dv/pfl_host_model.sv ====
// host board model driving the power-on request of the supply
`timescale 1ns/100ps
module pfl_host_model #(
    parameter int HOLD = 20
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic wantOn,
    input  wire logic relReq,
    output logic      powerOnReq_n,
    output logic      cycling
);
    int cnt;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt          <= 0;
            powerOnReq_n <= 1'b1;
        end else if (relReq && cnt == 0) begin
            // two spare cycles cover the input register of the supply
            cnt          <= HOLD + 2;
            powerOnReq_n <= 1'b1;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end else begin
            powerOnReq_n <= ~wantOn;
        end
    end

    assign cycling = (cnt != 0);
endmodule : pfl_host_model

// ==== dv/tb_top.sv ====
// self-checking bench of the supply supervisor
`timescale 1ns/100ps
module tb_top import pfl_pkg::*; ;
    logic      ref_clk, srst, clkEn, acPresent, peerAcPresent, mainInReg, smartStandby, fwUpdate;
    logic      loadAboveRating, standbyFault, addr_strap_lo, addr_strap_hi, wantOn, relReq;
    pfl_crit_t crit;
    pfl_warn_t warn;
    wire logic powerOnReq_n, cycling, mainEnable, standby_rail_en, faultLatched, alert_n, ledGreen, ledAmber;
    pfl_addr_t addrs;
    int        fails, samples_checked, gTog, aTog, gOn, aOn;
    logic [7:0] e;

    pfl_supervisor #(.PSON_REL_CYC(20), .AC_REL_CYC(40), .CLOSED_LOOP_THROTTLE_CYC(10), .BLINK1_HALF(8), .BLINK2_HALF(4)) DUT (
        .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .powerOnReq_n(powerOnReq_n), .acPresent(acPresent),
        .peerAcPresent(peerAcPresent), .mainInReg(mainInReg), .smartStandby(smartStandby), .fwUpdate(fwUpdate),
        .loadAboveRating(loadAboveRating), .standbyFault(standbyFault), .addr_strap_lo(addr_strap_lo),
        .addr_strap_hi(addr_strap_hi), .crit(crit), .warn(warn), .mainEnable(mainEnable),
        .standby_rail_en(standby_rail_en), .faultLatched(faultLatched), .alert_n(alert_n),
        .ledGreen(ledGreen), .ledAmber(ledAmber), .addrs(addrs));

    pfl_host_model #(.HOLD(20)) host (.ref_clk(ref_clk), .srst(srst), .wantOn(wantOn), .relReq(relReq),
        .powerOnReq_n(powerOnReq_n), .cycling(cycling));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // counts led toggles and lit cycles over a window
    task automatic watch(input int n);
        logic pg, pa;
        {gTog, aTog, gOn, aOn} = '0;
        pg = ledGreen;
        pa = ledAmber;
        repeat (n) begin
            step(1);
            gTog += int'(ledGreen !== pg);
            aTog += int'(ledAmber !== pa);
            gOn += int'(ledGreen === 1'b1);
            aOn += int'(ledAmber === 1'b1);
            pg = ledGreen;
            pa = ledAmber;
        end
    endtask : watch

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic release_latch;
        int i;
        relReq = 1'b1;
        step(1);
        relReq = 1'b0;
        for (i = 0; i < 100 && cycling; i++) step(1);
        if (cycling) begin
            fails++;
            end_of_test();
        end
        step(4);
    endtask : release_latch

    initial begin
        {srst, clkEn} = 2'b11;
        {acPresent, peerAcPresent, mainInReg, smartStandby, fwUpdate} = '0;
        {loadAboveRating, standbyFault, addr_strap_lo, addr_strap_hi, wantOn, relReq} = '0;
        crit = '0;
        warn = '0;
        step(6);
        chk({mainEnable, standby_rail_en, faultLatched, alert_n, ledGreen, ledAmber}, 16'h0004);
        chk(addrs, 16'hA0B0);
        srst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {addr_strap_hi, addr_strap_lo} = 2'(i);
            step(2);
            e = 8'(2 * (i % 2) + 4 * (i / 2));
            chk(addrs, {8'hA0 + e, 8'hB0 + e});
        end
        $display("test straps done");
        {acPresent, peerAcPresent, mainInReg, wantOn} = 4'hF;
        step(4);
        chk({mainEnable, standby_rail_en, alert_n}, 16'h0007);
        watch(32);
        chk({gOn[7:0], aOn[7:0]}, 16'h2000);
        // output on but out of regulation: not steady green
        mainInReg = 1'b0;
        step(2);
        watch(32);
        chk(16'(gTog >= 3 && gTog <= 4 && aOn == 0), 16'h0001);
        mainInReg = 1'b1;
        wantOn = 1'b0;
        step(4);
        chk(mainEnable, 16'h0000);
        watch(32);
        chk(16'(gTog >= 3 && gTog <= 4 && aOn == 0), 16'h0001);
        wantOn = 1'b1;
        smartStandby = 1'b1;
        step(4);
        watch(32);
        chk(16'(gTog >= 3 && gTog <= 4), 16'h0001);
        clkEn = 1'b0;
        watch(20);
        chk(16'(gTog), 16'h0000);
        clkEn = 1'b1;
        smartStandby = 1'b0;
        $display("test power states done");
        for (int i = 0; i < 6; i++) begin
            crit[i] = 1'b1;
            fwUpdate = 1'b1;
            step(2);
            chk({mainEnable, faultLatched, alert_n, ledAmber, ledGreen}, 16'h000A);
            chk(standby_rail_en, 16'h0001);
            crit = '0;
            fwUpdate = 1'b0;
            step(4);
            chk({mainEnable, faultLatched}, 16'h0001);
            release_latch();
            chk({mainEnable, faultLatched}, 16'h0002);
        end
        $display("test critical latch done");
        standbyFault = 1'b1;
        step(2);
        chk({standby_rail_en, mainEnable}, 16'h0001);
        standbyFault = 1'b0;
        step(2);
        chk(standby_rail_en, 16'h0001);
        $display("test standby fault done");
        for (int i = 0; i < 5; i++) begin
            warn[i] = 1'b1;
            step(2);
            chk(alert_n, 16'h0000);
            watch(32);
            chk(16'(aTog >= 3 && aTog <= 4 && gOn == 0), 16'h0001);
            chk({mainEnable, alert_n}, 16'h0002);
            warn = '0;
            step(2);
            chk(alert_n, 16'h0001);
        end
        fwUpdate = 1'b1;
        warn.slowFan = 1'b1;
        watch(32);
        chk(16'(gTog >= 7 && gTog <= 8 && aOn == 0), 16'h0001);
        {fwUpdate, warn} = '0;
        $display("test warnings done");
        warn.tempWarn = 1'b1;
        loadAboveRating = 1'b1;
        step(8);
        loadAboveRating = 1'b0;
        step(4);
        chk({mainEnable, faultLatched}, 16'h0002);
        loadAboveRating = 1'b1;
        step(16);
        chk({mainEnable, faultLatched}, 16'h0001);
        {loadAboveRating, warn} = '0;
        release_latch();
        chk(mainEnable, 16'h0001);
        $display("test throttle done");
        crit.overcurrentTrip = 1'b1;
        step(2);
        crit = '0;
        acPresent = 1'b0;
        step(2);
        chk({alert_n, ledAmber, ledGreen}, 16'h0002);
        peerAcPresent = 1'b0;
        step(2);
        // the latched fault still outranks the dark led
        chk({ledAmber, ledGreen}, 16'h0002);
        step(50);
        chk({ledAmber, ledGreen, faultLatched}, 16'h0000);
        peerAcPresent = 1'b1;
        step(2);
        chk({alert_n, ledAmber, ledGreen}, 16'h0002);
        acPresent = 1'b1;
        step(4);
        chk({mainEnable, faultLatched}, 16'h0002);
        $display("test input loss done");
        end_of_test();
    end
endmodule : tb_top
